//--- verification/qsr_checker.sv
`timescale 1ns/1ps
module qsr_checker
  import qsr_pkg::*;
#(
  parameter int DIV_W = QSR_DIV_W
) (
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             ce,
  input wire logic [DIV_W-1:0] serialClockConfig,
  input wire logic [1:0]       csLeadDelayField,
  input wire logic             memReq,
  input wire logic             memAck,
  input wire logic             busy,
  input wire logic             irq,
  input wire logic             irqOnFrame,
  input wire logic             sclk,
  input wire logic             csN,
  input wire logic [3:0]       dOut
);
  logic [15:0] halfCyc;
  logic [15:0] sinceCs_r;
  logic [15:0] sinceFall_r;
  logic [15:0] leadT_r;
  logic [15:0] lagT_r;
  logic        sclkD_r;
  logic        fellSeen_r;
  logic        fellNow;

  assign halfCyc = (serialClockConfig == '0) ? 16'h2 :
                   16'(serialClockConfig) + 16'h1;
  assign fellNow = sclkD_r & ~sclk;

  // targets latched while idle, as the divider is only taken between frames
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkD_r     <= 1'b0;
      sinceCs_r   <= 16'h0;
      sinceFall_r <= 16'h0;
      fellSeen_r  <= 1'b0;
      leadT_r     <= 16'h0;
      lagT_r      <= 16'h0;
    end else if (ce) begin
      sclkD_r     <= sclk;
      sinceCs_r   <= csN ? 16'h0 : sinceCs_r + 16'h1;
      sinceFall_r <= fellNow ? 16'h1 : sinceFall_r + 16'h1;
      fellSeen_r  <= !csN && (fellSeen_r || fellNow);
      if (csN) begin
        leadT_r <= (16'(csLeadDelayField) + 16'h1) * halfCyc * 16'h2;
        lagT_r  <= halfCyc * 16'h4;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence sTake;
    ce && memReq && !memAck && !busy;
  endsequence
  sequence sSelected;
    !csN && busy;
  endsequence

  AST_TAKE: assert property (sTake |=> sSelected)
    else $error("memory request not started");
  AST_IDLE_LOW: assert property (csN |-> !sclk)
    else $error("serial clock not low outside frame");
  AST_BUSY_CS: assert property (!csN |-> busy)
    else $error("busy low while selected");
  AST_HALF_MIN: assert property ($changed(sclk) |=> $stable(sclk))
    else $error("serial clock half period too short");
  AST_CS_LEAD: assert property (fellNow && !fellSeen_r |->
    sinceCs_r == leadT_r)
    else $error("chip select lead wrong");
  AST_CS_LAG: assert property ($rose(csN) |-> sinceFall_r == lagT_r)
    else $error("chip select lag wrong");
  AST_ACK: assert property (memAck |-> $rose(csN) ##1 !memAck)
    else $error("memory acknowledge misplaced");
  AST_D0_EDGE: assert property ($changed(dOut[0]) && !csN |-> !sclk)
    else $error("data line 0 moved with clock high");
  AST_IRQ_FRAME: assert property (irq && irqOnFrame |-> $rose(csN))
    else $error("frame interrupt not at frame end");
endmodule

//--- verification/qsr_controller_test.sv
`timescale 1ns/1ps
module qsr_controller_test;
  import qsr_pkg::*;
  localparam logic [127:0] STREAM =
    128'hc3a5_1e96_f00f_5a3c_7e81_24db_9c63_b54a;
  logic         clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic         memReq = 1'b0, swStart = 1'b0, cmdEnable = 1'b0;
  logic         irqEnable = 1'b1, irqOnFrame = 1'b0;
  logic [7:0]   serialClockConfig = 8'h1;
  logic [1:0]   csLeadDelayField = 2'h0, pinMode = 2'h2, readWidth = 2'h0;
  logic [6:0]   wordLenM1 = 7'h7;
  logic [11:0]  wordCntM1 = 12'h0;
  logic         busy, rxValid, memAck, irq, sclk, csN;
  logic [127:0] rxData;
  logic [31:0]  memRdata;
  logic [3:0]   dOut, dOe, dIn, flashD;
  logic [2:0]   lines = 3'h1;
  logic [1:0]   lane = 2'h0;
  logic [7:0]   skip = 8'h0;
  int           errors = 0, checks_done = 0;
  logic [31:0]  cmdSeen = 32'h0;
  int           cmdBits = 0;

  always #20 clk = ~clk;
  assign dIn = (dOe & dOut) | (~dOe & flashD);

  // command bits as the target clocks them in on rising edges
  always @(negedge csN) cmdBits = 0;
  always @(posedge sclk) if (!csN && cmdBits < 32) begin
    cmdSeen = {cmdSeen[30:0], dOut[0]};
    cmdBits++;
  end

  qsr_controller dut_u (.clk, .arst_n, .ce, .serialClockConfig,
    .csLeadDelayField, .pinMode, .readWidth, .wordLenM1, .wordCntM1,
    .cmdEnable, .cmdOpcode(8'h6b), .cmdAddr(24'h00_0100), .irqEnable,
    .irqOnFrame, .swStart, .busy, .rxData, .rxValid, .memReq,
    .memAddr(24'h01_2340), .memRdata, .memAck, .irq, .sclk, .csN, .dOut,
    .dOe, .dIn);
  qsr_flash_model flash_u (.sclk, .csN, .lines, .lane, .skip,
    .stream(STREAM), .flashD);

  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [127:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 20000) begin
      errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      test_done();
    end
  endtask

  task automatic mem_read(input logic [1:0] pm, lead, input logic [7:0] dv);
    int n = 0;
    @(negedge clk);
    pinMode = pm;
    csLeadDelayField = lead;
    serialClockConfig = dv;
    lines = 3'h1;
    lane = (pm == QSR_PINS_3) ? 2'h0 : 2'h1;
    skip = 8'd32;
    memReq = 1'b1;
    while (memAck !== 1'b1) tick(n);
    chk("memRdata", {96'h0, STREAM[127:96]}, {96'h0, memRdata});
    chk("cmdSeen", {96'h0, 32'h6b01_2340}, {96'h0, cmdSeen});
    @(negedge clk);
    memReq = 1'b0;
  endtask

  task automatic sw_read(input logic [1:0] rw, pm, input int len, cnt,
                         input logic onFrame, cmd, ie);
    int n = 0;
    int words = 0;
    int irqs = 0;
    @(negedge clk);
    readWidth = rw;
    pinMode = pm;
    wordLenM1 = 7'(len - 1);
    wordCntM1 = 12'(cnt - 1);
    irqOnFrame = onFrame;
    irqEnable = ie;
    cmdEnable = cmd;
    skip = cmd ? 8'd32 : 8'h0;
    lines = (rw == QSR_RD_QUAD) ? 3'h4 : (rw == QSR_RD_DUAL) ? 3'h2 : 3'h1;
    lane = (pm == QSR_PINS_3) ? 2'h0 : 2'h1;
    swStart = 1'b1;
    @(negedge clk);
    swStart = 1'b0;
    chk("busy", 1, {127'h0, busy});
    // mid-frame divider change and a start that must be ignored
    if (cmd) begin
      serialClockConfig = 8'h6;
      swStart = 1'b1;
      @(negedge clk);
      swStart = 1'b0;
    end
    while (busy === 1'b1) begin
      tick(n);
      if (rxValid === 1'b1) begin
        chk("rxData", (STREAM << (words * len)) >> (128 - len), rxData);
        words++;
      end
      if (irq === 1'b1) irqs++;
    end
    chk("words", cnt, words);
    chk("irqs", ie ? (onFrame ? 1 : cnt) : 0, irqs);
    if (cmd) chk("cmdSeen", {96'h0, 32'h6b00_0100}, {96'h0, cmdSeen});
    tick(n);
    tick(n);
    chk("idle", 0, {127'h0, busy});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++)
      mem_read(2'(i % 3), 2'(i), 8'(i));
    sw_read(QSR_RD_QUAD, QSR_PINS_6, 8, 3, 1'b0, 1'b0, 1'b1);
    sw_read(QSR_RD_DUAL, QSR_PINS_4, 6, 2, 1'b1, 1'b0, 1'b1);
    sw_read(QSR_RD_SINGLE, QSR_PINS_3, 128, 1, 1'b1, 1'b1, 1'b1);
    sw_read(QSR_RD_SINGLE, QSR_PINS_6, 1, 4, 1'b0, 1'b0, 1'b0);
    test_done();
  end
endmodule

bind qsr_controller qsr_checker #(.DIV_W(DIV_W)) chk_u (.clk, .arst_n, .ce,
  .serialClockConfig, .csLeadDelayField, .memReq, .memAck, .busy, .irq,
  .irqOnFrame, .sclk, .csN, .dOut);

//--- verification/qsr_flash_model.sv
`timescale 1ns/1ps
module qsr_flash_model (
  input wire logic         sclk,
  input wire logic         csN,
  input wire logic [2:0]   lines,
  input wire logic [1:0]   lane,
  input wire logic [7:0]   skip,
  input wire logic [127:0] stream,
  output logic [3:0]       flashD
);
  int falls = 0;
  initial flashD = 4'h5;

  // idle lanes toggle every launch so a stale bit never passes for data
  task automatic launch;
    int b;
    int top;
    b = (falls - skip) * lines;
    top = (lines == 3'h1) ? lane : lines - 1;
    flashD = ~flashD;
    if (falls >= skip)
      for (int i = 0; i < lines; i++)
        flashD[top - i] = stream[(127 - b - i) & 127];
  endtask

  always @(negedge csN) begin
    falls = 0;
    launch();
  end
  always @(negedge sclk) if (!csN) begin
    falls++;
    launch();
  end
  always @(posedge csN) flashD = ~flashD;
endmodule

//--- verilog/qsr_controller.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] always the bus controller: drives serial clock and chip select
// [R2] reads use one, two or four data lines
// [R3] memory-mapped read request becomes a serial read automatically
// [R4] word length programmable from 1 to 128 bits
// [R5] words per frame programmable from 1 to 4096
// [R6] serial bus runs as a 3-, 4- or 6-pin interface
// [R7] optional interrupt on word or on frame completion
// [R8] 0 to 3 clock delay between chip select and first data
// [R9] clock mode 0: clock idles low, phase 0
// [R10] read data sampled at falling serial clock edges
// [R11] target launches read data at falling edges
// [R12] chip select asserted delay-plus-one periods before first falling edge
// [R13] chip select released two periods after final falling edge
// [R14] data line 0 changes in step with falling edges
// [R15] first data transition one period ahead of first falling edge; for delay 0 the code drives it one clock after chip select instead
// [R16] serial clock period never below 25 ns
// [R17] frame ends after last word; chip select off, clock held low
// [R18] integer clock divider, changes applied only between frames
module qsr_controller
  import qsr_pkg::*;
#(
  parameter int DIV_W = QSR_DIV_W,
  parameter int LEN_W = QSR_LEN_W,
  parameter int CNT_W = QSR_CNT_W
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic [DIV_W-1:0]      serialClockConfig,
  input  wire logic [1:0]            csLeadDelayField,
  input  wire logic [1:0]            pinMode,
  input  wire logic [1:0]            readWidth,
  input  wire logic [LEN_W-1:0]      wordLenM1,
  input  wire logic [CNT_W-1:0]      wordCntM1,
  input  wire logic                  cmdEnable,
  input  wire logic [QSR_OPC_W-1:0]  cmdOpcode,
  input  wire logic [QSR_ADDR_W-1:0] cmdAddr,
  input  wire logic                  irqEnable,
  input  wire logic                  irqOnFrame,
  input  wire logic                  swStart,
  output logic                       busy,
  output logic [QSR_WORD_W-1:0]      rxData,
  output logic                       rxValid,
  input  wire logic                  memReq,
  input  wire logic [QSR_ADDR_W-1:0] memAddr,
  output logic [31:0]                memRdata,
  output logic                       memAck,
  output logic                       irq,
  output logic                       sclk,
  output logic                       csN,
  output logic [3:0]                 dOut,
  output logic [3:0]                 dOe,
  input  wire logic [3:0]            dIn
);

  qsr_state_t                state_r;
  logic [DIV_W:0]            halfLen_r;
  logic [DIV_W:0]            divCnt_r;
  logic [3:0]                halfCnt_r;
  logic [1:0]                lead_r;
  logic [1:0]                pins_r;
  logic [2:0]                lines_r;
  logic [LEN_W:0]            len_r;
  logic [LEN_W:0]            bitsLeft_r;
  logic [CNT_W-1:0]          wordsLeft_r;
  logic [5:0]                cmdLeft_r;
  logic [31:0]               cmdSh_r;
  logic                      fromMem_r;
  logic                      frameIrq_r;
  logic [QSR_WORD_W-1:0]     rxSh_r;
  logic [QSR_WORD_W-1:0]     rxData_r;
  logic                      rxValid_r;
  logic                      memAck_r;
  logic                      irq_r;
  logic                      sclk_r;
  logic                      csN_r;
  logic [3:0]                dOut_r;
  logic [3:0]                dOe_r;
  logic [3:0]                dMeta_r;
  logic [3:0]                dSync_r;

  // selection and decode
  wire             idle      = (state_r == QSR_ST_IDLE);
  wire             memGo     = idle && memReq && !memAck_r;
  wire             swGo      = idle && swStart && !memGo;
  wire             go        = memGo || swGo;
  wire             tick      = !idle && (divCnt_r == '0);
  wire [DIV_W:0]   divPlus   = {1'b0, serialClockConfig} + 1'b1;
  wire [DIV_W:0]   halfMin   = (DIV_W+1)'(QSR_HALF_MIN);
  wire [DIV_W:0]   halfSel   = (divPlus < halfMin) ? halfMin : divPlus; // R16
  wire [3:0]       nextHalf  = halfCnt_r + 4'h1;
  wire [3:0]       leadHalfs = {1'b0, lead_r, 1'b0} + 4'h2;  // 2*M R12
  wire [3:0]       lagHalfs  = 4'(2 * QSR_CS_LAG_PER);
  wire             fall      = tick && (state_r == QSR_ST_XFER) && sclk_r;
  wire             cmdPhase  = (cmdLeft_r != '0);
  wire             lastCmd   = (cmdLeft_r == 6'h1);
  wire [2:0]       take      =
    ({1'b0, bitsLeft_r} < (LEN_W+1)'(lines_r)) ? bitsLeft_r[2:0] : lines_r;
  wire [LEN_W:0]   bitsNext  = bitsLeft_r - (LEN_W+1)'(take);
  wire             wordEnd   = fall && !cmdPhase && (bitsNext == '0);
  wire             frameEnd  = wordEnd && (wordsLeft_r == '0);

  // effective line count: pin arrangement limits the width
  wire [2:0] linesSel =
    (pinMode == QSR_PINS_6 && readWidth == QSR_RD_QUAD) ? 3'h4 :
    (pinMode != QSR_PINS_3 && readWidth != QSR_RD_SINGLE) ? 3'h2 :
    3'h1;                                                    // R2 R6

  // read-phase enables: line 0 turns around only in 3-pin mode or when
  // it carries data; 6-pin single holds lines 2 and 3 high as controls
  wire [3:0] rdOe =
    (pins_r == QSR_PINS_3) ? 4'h0 :
    (pins_r == QSR_PINS_4) ? ((lines_r == 3'h1) ? 4'h1 : 4'h0) :
    (lines_r == 3'h4) ? 4'h0 :
    (lines_r == 3'h2) ? 4'hc : 4'hd;                         // R6
  wire [3:0] rdOut = (pins_r == QSR_PINS_6) ? 4'hc : 4'h0;
  wire [3:0] cmdOe = (pins_r == QSR_PINS_6) ? 4'hd : 4'h1;
  wire [3:0] cmdOut = {rdOut[3:2], 1'b0, cmdSh_r[31]};
  wire [3:0] firstOe  = cmdPhase ? cmdOe : rdOe;
  wire [3:0] firstOut = cmdPhase ? cmdOut : rdOut;

  // capture up to four bits per edge, highest line first
  function automatic logic [QSR_WORD_W-1:0] shiftIn(
    input logic [QSR_WORD_W-1:0] s,
    input logic [3:0]            d,
    input logic [2:0]            lines,
    input logic [2:0]            n
  );
    logic [QSR_WORD_W-1:0] r;
    int                    idx;
    r = s;
    for (int i = 0; i < 4; i++) begin
      idx = int'(lines) - 1 - i;
      if (i < int'(n) && idx >= 0)
        r = {r[QSR_WORD_W-2:0], d[idx[1:0]]};
    end
    return r;
  endfunction

  // single-line reads arrive on line 1 unless line 0 is turned around
  wire [3:0] dRd = (lines_r == 3'h1 && pins_r != QSR_PINS_3) ?
                   {3'h0, dSync_r[1]} : dSync_r;             // R6

  wire [QSR_WORD_W-1:0] rxShNext = shiftIn(rxSh_r, dRd, lines_r, take);

  // pin synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dMeta_r <= QSR_D_RST;
      dSync_r <= QSR_D_RST;
    end else if (ce) begin
      dMeta_r <= dIn;
      dSync_r <= dMeta_r;
    end
  end

  // divider; reload value latched only while idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halfLen_r <= (DIV_W+1)'(QSR_HALF_MIN);
      divCnt_r  <= '0;
    end else if (ce) begin
      if (idle)
        halfLen_r <= halfSel;                                // R18
      if (idle || tick)
        divCnt_r <= (idle ? halfSel : halfLen_r) - 1'b1;     // R18
      else
        divCnt_r <= divCnt_r - 1'b1;
    end
  end

  // frame configuration, latched at start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lead_r     <= 2'h0;
      pins_r     <= QSR_PINS_3;
      lines_r    <= 3'h1;
      len_r      <= '0;
      fromMem_r  <= 1'b0;
      frameIrq_r <= 1'b0;
    end else if (ce && go) begin
      lead_r     <= csLeadDelayField;                        // R8
      pins_r     <= pinMode;
      lines_r    <= memGo ? 3'h1 : linesSel;
      len_r      <= memGo ? (LEN_W+1)'(QSR_MEM_WORD_BITS)
                          : {1'b0, wordLenM1} + 1'b1;        // R4
      fromMem_r  <= memGo;
      frameIrq_r <= irqOnFrame;
    end
  end

  // frame sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= QSR_ST_IDLE;
      halfCnt_r   <= 4'h0;
      sclk_r      <= 1'b0;
      csN_r       <= 1'b1;
      cmdLeft_r   <= 6'h0;
      cmdSh_r     <= 32'h0;
      bitsLeft_r  <= '0;
      wordsLeft_r <= '0;
    end else if (ce) begin
      unique case (state_r)
        QSR_ST_IDLE: begin
          sclk_r    <= 1'b0;                                 // R9 R17
          halfCnt_r <= 4'h0;
          if (go) begin
            state_r     <= QSR_ST_LEAD;
            csN_r       <= 1'b0;                             // R1 R12
            cmdLeft_r   <= (memGo || cmdEnable) ?
                           6'(QSR_MEM_CMD_BITS) : 6'h0;      // R3
            cmdSh_r     <= memGo ? {cmdOpcode, memAddr}
                                 : {cmdOpcode, cmdAddr};     // R3
            bitsLeft_r  <= memGo ? (LEN_W+1)'(QSR_MEM_WORD_BITS)
                                 : {1'b0, wordLenM1} + 1'b1;
            wordsLeft_r <= memGo ? '0 : wordCntM1;           // R5
          end
        end
        QSR_ST_LEAD: if (tick) begin
          halfCnt_r <= nextHalf;
          if (nextHalf == leadHalfs - 4'h1) begin
            sclk_r    <= 1'b1;
            state_r   <= QSR_ST_XFER;
          end
        end
        QSR_ST_XFER: if (tick) begin
          sclk_r <= !sclk_r && !frameEnd;
          if (fall && cmdPhase) begin
            cmdLeft_r <= cmdLeft_r - 6'h1;
            cmdSh_r   <= {cmdSh_r[30:0], 1'b0};              // R14
          end else if (fall) begin
            bitsLeft_r <= (bitsNext == '0) ? len_r : bitsNext;
            if (wordEnd && !frameEnd)
              wordsLeft_r <= wordsLeft_r - 1'b1;
          end
          if (frameEnd) begin
            state_r   <= QSR_ST_LAG;                         // R17
            halfCnt_r <= 4'h0;
          end
        end
        QSR_ST_LAG: if (tick) begin
          halfCnt_r <= nextHalf;
          if (nextHalf == lagHalfs) begin
            csN_r   <= 1'b1;                                 // R13 R17
            state_r <= QSR_ST_IDLE;
          end
        end
        default: state_r <= QSR_ST_IDLE;
      endcase
    end
  end

  // data line drive: first value one period before the first falling
  // edge (for delay 0, one clock after chip select, one clock short of
  // a period), later values only on falling edges
  wire firstDrive = (state_r == QSR_ST_LEAD) &&
                    ((tick && nextHalf == leadHalfs - 4'h2) ||
                     (halfCnt_r == 4'h0 && lead_r == 2'h0 &&
                      !dOe_r[0] && dOe_r == 4'h0 && !tick));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dOut_r <= QSR_D_RST;
      dOe_r  <= QSR_D_RST;
    end else if (ce) begin
      if (idle) begin
        dOut_r <= QSR_D_RST;
        dOe_r  <= QSR_D_RST;
      end else if (firstDrive) begin
        dOut_r <= firstOut;                                  // R15 R8
        dOe_r  <= firstOe;
      end else if (fall && cmdPhase) begin
        dOut_r <= lastCmd ? rdOut : {cmdOut[3:1], cmdSh_r[30]}; // R14
        dOe_r  <= lastCmd ? rdOe : cmdOe;
      end
    end
  end

  // read capture on falling edges; the target launched on the previous
  // fall, and the synchroniser delay is covered by the two-cycle minimum
  // half period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxSh_r    <= QSR_RX_RST;
      rxData_r  <= QSR_RX_RST;
      rxValid_r <= 1'b0;
      memAck_r  <= 1'b0;
      irq_r     <= 1'b0;
    end else if (ce) begin
      rxValid_r <= 1'b0;
      memAck_r  <= 1'b0;
      irq_r     <= 1'b0;
      if (go)
        rxSh_r <= QSR_RX_RST;
      else if (fall && !cmdPhase)
        rxSh_r <= wordEnd ? QSR_RX_RST : rxShNext;           // R10 R11
      if (wordEnd) begin
        rxData_r  <= rxShNext;
        rxValid_r <= !fromMem_r;
        irq_r     <= irqEnable && !fromMem_r && !frameIrq_r; // R7
      end
      if ((state_r == QSR_ST_LAG) && tick && nextHalf == lagHalfs) begin
        memAck_r <= fromMem_r;                               // R3
        irq_r    <= irqEnable && !fromMem_r && frameIrq_r;   // R7
      end
    end
  end

  assign busy     = !idle;
  assign rxData   = rxData_r;
  assign rxValid  = rxValid_r;
  assign memRdata = rxData_r[31:0];
  assign memAck   = memAck_r;
  assign irq      = irq_r;
  assign sclk     = sclk_r;
  assign csN      = csN_r;
  assign dOut     = dOut_r;
  assign dOe      = dOe_r;

endmodule

//--- verilog/qsr_pkg.sv
package qsr_pkg;

  // serial bus pin arrangements
  localparam logic [1:0] QSR_PINS_3 = 2'h0;
  localparam logic [1:0] QSR_PINS_4 = 2'h1;
  localparam logic [1:0] QSR_PINS_6 = 2'h2;

  // read widths
  localparam logic [1:0] QSR_RD_SINGLE = 2'h0;
  localparam logic [1:0] QSR_RD_DUAL   = 2'h1;
  localparam logic [1:0] QSR_RD_QUAD   = 2'h2;

  // field widths
  localparam int QSR_DIV_W  = 8;
  localparam int QSR_LEN_W  = 7;
  localparam int QSR_CNT_W  = 12;
  localparam int QSR_WORD_W = 128;

  // timing
  localparam int QSR_CLK_NS       = 40;
  localparam int QSR_SCLK_MIN_NS  = 25;
  localparam int QSR_SYNC_HALF    = 2;
  localparam int QSR_NS_HALF      =
    (QSR_SCLK_MIN_NS + 2 * QSR_CLK_NS - 1) / (2 * QSR_CLK_NS);
  localparam int QSR_HALF_MIN     =
    (QSR_NS_HALF > QSR_SYNC_HALF) ? QSR_NS_HALF : QSR_SYNC_HALF;
  localparam int QSR_CS_LAG_PER   = 2;

  // memory-mapped read frame
  localparam int QSR_MEM_CMD_BITS  = 32;
  localparam int QSR_MEM_WORD_BITS = 32;
  localparam int QSR_ADDR_W        = 24;
  localparam int QSR_OPC_W         = 8;

  // reset values
  localparam logic [QSR_WORD_W-1:0] QSR_RX_RST = 128'h0;
  localparam logic [3:0]            QSR_D_RST  = 4'h0;

  typedef enum logic [3:0] {
    QSR_ST_IDLE = 4'h1,
    QSR_ST_LEAD = 4'h2,
    QSR_ST_XFER = 4'h4,
    QSR_ST_LAG  = 4'h8
  } qsr_state_t;

endpackage
